// [include/oss_defs.svh]
`ifndef OSS_DEFS_SVH
`define OSS_DEFS_SVH

// Register byte offsets
`define OSS_REG_CFG 8'h00
`define OSS_REG_SEQ 8'h04
`define OSS_REG_CMD 8'h08
`define OSS_REG_STATUS 8'h0C
`define OSS_REG_STEP_A 8'h10
`define OSS_REG_STEP_B 8'h14
`define OSS_REG_STEP_C 8'h18
`define OSS_REG_STEP_D 8'h1C
`define OSS_REG_STEP_WR 8'h20
`define OSS_REG_WAVE_ADDR 8'h24
`define OSS_REG_WAVE_DATA 8'h28

// Configuration field positions
`define OSS_CFG_MODE 0
`define OSS_CFG_KIND_LO 1
`define OSS_CFG_CONT 3
`define OSS_CFG_EXT_EN 4
`define OSS_CFG_SRC_LO 5
`define OSS_CFG_WAVE_WEN 7

// Command bits
`define OSS_CMD_START 0
`define OSS_CMD_STOP 1
`define OSS_CMD_HOLD 2
`define OSS_CMD_BRANCH 3

// Reset values
`define OSS_CFG_RST 8'h00
`define OSS_SEQ_RST 26'h000_0401

// Limits
`define OSS_STEP_MAX 255
`define OSS_JUMP_MAX 999
`define OSS_FIFO_DEPTH 16
`define OSS_WAVE_COUNT 16
`define OSS_WAVE_LEN 1024

// Timing
`define OSS_CLK_NS 10
`define OSS_TICK_NS 100000
`define OSS_SAMPLE_NS 2000000

`endif

// [include/oss_pkg.sv]
package oss_pkg;

  // Sequencer states, Gray along idle-load-run-hold
  typedef enum logic [1:0] {
    OSS_IDLE = 2'h0,
    OSS_LOAD = 2'h1,
    OSS_RUN = 2'h3,
    OSS_HOLD = 2'h2
  } oss_state_t;

  typedef enum logic [1:0] {
    OSS_SINE = 2'h0,
    OSS_SQUARE = 2'h1,
    OSS_ARB = 2'h2
  } oss_kind_t;

  typedef enum logic [1:0] {
    OSS_SRC_INT = 2'h0,
    OSS_SRC_EXT = 2'h1,
    OSS_SRC_BOTH = 2'h2
  } oss_src_t;

  // One stored step
  typedef struct packed {
    logic [23:0] dur;
    logic [15:0] dc_inc;
    logic [15:0] ac_inc;
    logic [15:0] dc;
    logic [15:0] ac;
    logic [19:0] freq;
    logic [3:0] wave;
    logic [1:0] sync;
    logic sweep;
  } oss_step_t;

endpackage

// [rtl/oss_fifo.sv]
`timescale 1ns/1ps
module oss_fifo #(
  parameter int W = 30,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic in_valid, // Source offers a word
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Sink takes the word
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("oss_fifo: depth must be a power of two");
  end

  logic [W-1:0] buf_r [0:DEPTH-1];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Extra pointer bit tells full from empty
  assign in_ready = !((wp_r[AW] != rp_r[AW]) &&
                      (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data = buf_r[rp_r[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      buf_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
endmodule // oss_fifo

// [rtl/oss_mem.sv]
`timescale 1ns/1ps
module oss_mem #(
  parameter int DW = 16,
  parameter int AW = 10
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Resets read data only
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write address
  input wire logic [DW-1:0] wr_data, // Write data
  input wire logic rd_en, // Read strobe
  input wire logic [AW-1:0] rd_addr, // Read address
  output logic [DW-1:0] rd_data // Registered read data
);
  if (DW < 1 || AW < 1) begin : g_chk
    $error("oss_mem: bad width");
  end

  // No reset on the array: contents live in the battery-held domain
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data from a flop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // oss_mem

// [rtl/oss_sequencer.sv]
`timescale 1ns/1ps
`include "oss_defs.svh"
// Functional notes
// - One stored sequence per voltage/current mode.
// - Each sequence holds one to 255 steps.
// - Step time 0.1 ms to 999.9999 s; the 24-bit duration accepts up to 1677.7215 s.
// - Step holds constant or sweeps linearly.
// - Step carries levels, frequency, waveform, sync.
// - Repeat by jump count or continuously.
// - Hold freezes timer and present outputs.
// - Start after hold resumes, not restarts.
// - Branch jumps at once to preset step.
// - Sine or square stays fixed all run.
// - Arbitrary mode lets each step pick waveform.
// - Refuse to run on external source alone.
// - Sequence settings kept in battery storage.
// - Sixteen waveform memories, 1024 by 16 bits.
// - Waveform memory kept by battery backup.
// - Waveform writes only from USB, never panel.
// - External falling edges, sampled every 2 ms.
module oss_sequencer #(
  parameter int TICK_CYC = `OSS_TICK_NS / `OSS_CLK_NS,
  parameter int SAMPLE_CYC = `OSS_SAMPLE_NS / `OSS_CLK_NS,
  parameter int FIFO_DEPTH = `OSS_FIFO_DEPTH
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst, // Async reset, high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic reg_from_usb, // Access comes from the USB host
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic ext_start_n, // External start, falling edge
  input wire logic ext_stop_n, // External stop, falling edge
  input wire logic ext_hold_n, // External hold, falling edge
  input wire logic ext_branch_n, // External branch, falling edge
  input wire logic [9:0] gen_phase, // Sample index from generator
  output logic [15:0] gen_sample, // Arbitrary waveform sample
  output logic [15:0] dc_level, // DC level of source
  output logic [15:0] ac_amp, // Superimposed AC amplitude
  output logic [19:0] freq, // AC frequency setting
  output logic [1:0] wave_kind, // Sine, square or arbitrary
  output logic [3:0] wave_sel, // Arbitrary memory in use
  output logic [1:0] step_sync, // Step sync output
  output logic seq_running, // Sequence active or held
  output logic wave_fifo_ready // Waveform FIFO has room
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int SW = $clog2(SAMPLE_CYC + 1);
  localparam int RW = $bits(oss_pkg::oss_step_t);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
  localparam logic [SW-1:0] SAMP_LAST = SW'(SAMPLE_CYC - 1);
  localparam logic [9:0] JUMP_MAX = 10'(`OSS_JUMP_MAX);

  if (TICK_CYC < 1 || SAMPLE_CYC < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("oss_sequencer: bad timing or depth parameter");
  end

  // Software registers
  logic [7:0] cfg_r;
  logic [25:0] seq_r;
  logic [31:0] stg_a_r;
  logic [26:0] stg_b_r;
  logic [23:0] stg_c_r;
  logic [31:0] stg_d_r;
  logic [13:0] wave_addr_r;
  logic [31:0] reg_rdata_r;

  // Sequencer state
  oss_pkg::oss_state_t state_r, state_nxt;
  oss_pkg::oss_kind_t kind_r;
  logic [7:0] idx_r, idx_nxt;
  logic [9:0] pass_r, pass_nxt;
  logic [23:0] timer_r;
  logic [TW-1:0] tick_cnt_r;
  logic [SW-1:0] samp_cnt_r;
  logic [3:0] ext_q_r;
  logic [3:0] ext_prev_r;
  logic refused_r;
  logic [15:0] dc_r, ac_r;
  logic [19:0] freq_r;
  logic [3:0] wave_sel_r;
  logic [1:0] sync_r;
  oss_pkg::oss_step_t cur_r;

  // Address decode
  wire wr_cfg = reg_wr && (reg_addr == `OSS_REG_CFG);
  wire wr_seq = reg_wr && (reg_addr == `OSS_REG_SEQ);
  wire wr_cmd = reg_wr && (reg_addr == `OSS_REG_CMD);
  wire wr_a = reg_wr && (reg_addr == `OSS_REG_STEP_A);
  wire wr_b = reg_wr && (reg_addr == `OSS_REG_STEP_B);
  wire wr_c = reg_wr && (reg_addr == `OSS_REG_STEP_C);
  wire wr_d = reg_wr && (reg_addr == `OSS_REG_STEP_D);
  wire wr_step = reg_wr && (reg_addr == `OSS_REG_STEP_WR);
  wire wr_waddr = reg_wr && (reg_addr == `OSS_REG_WAVE_ADDR);
  wire wr_wdata = reg_wr && (reg_addr == `OSS_REG_WAVE_DATA);

  // Configuration fields
  wire mode_cc = cfg_r[`OSS_CFG_MODE];
  wire [1:0] kind_cfg = cfg_r[`OSS_CFG_KIND_LO +: 2];
  wire cont = cfg_r[`OSS_CFG_CONT];
  wire ext_en = cfg_r[`OSS_CFG_EXT_EN];
  wire [1:0] src_cfg = cfg_r[`OSS_CFG_SRC_LO +: 2];
  wire wave_wen = cfg_r[`OSS_CFG_WAVE_WEN];
  wire src_ok = (src_cfg == oss_pkg::OSS_SRC_INT) ||
                (src_cfg == oss_pkg::OSS_SRC_BOTH);

  // Zero counts read as one, jump counts clamp at the top
  wire [7:0] count = (seq_r[7:0] == 8'h00) ? 8'h01 : seq_r[7:0];
  wire [9:0] jumps_raw = seq_r[17:8];
  wire [9:0] jumps = (jumps_raw == 10'h000) ? 10'h001 :
                     (jumps_raw > JUMP_MAX) ? JUMP_MAX : jumps_raw;
  wire [7:0] br_tgt = (seq_r[25:18] < count) ? seq_r[25:18] : 8'h00;

  // Timing enables: 0.1 ms step tick, 2 ms input sample
  wire tick = (state_r == oss_pkg::OSS_RUN) &&
              (tick_cnt_r == TICK_LAST);
  wire samp_en = (samp_cnt_r == SAMP_LAST);
  wire [3:0] ext_fall = ext_prev_r & ~ext_q_r;
  wire samp_d = samp_en && ext_en;

  // Commands from software or from external falling edges
  wire c_start = (wr_cmd && reg_wdata[`OSS_CMD_START]) ||
                 (samp_d && ext_fall[0]);
  wire c_stop = (wr_cmd && reg_wdata[`OSS_CMD_STOP]) ||
                (samp_d && ext_fall[1]);
  wire c_hold = (wr_cmd && reg_wdata[`OSS_CMD_HOLD]) ||
                (samp_d && ext_fall[2]);
  wire c_branch = (wr_cmd && reg_wdata[`OSS_CMD_BRANCH]) ||
                  (samp_d && ext_fall[3]);

  // Step record just read from the step table
  oss_pkg::oss_step_t rec;
  wire [RW-1:0] rec_bits;
  assign rec = oss_pkg::oss_step_t'(rec_bits);
  wire last_step = (idx_r == (count - 8'h01));
  wire more_pass = cont || ((pass_r + 10'h001) < jumps);
  wire expire = tick && (timer_r == 24'h00_0001);
  wire go_load = (state_nxt == oss_pkg::OSS_LOAD);

  // Next state; stop wins, then branch, hold, start
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    pass_nxt = pass_r;
    case (state_r)
      oss_pkg::OSS_IDLE: begin
        if (c_start && !c_stop && src_ok) begin
          state_nxt = oss_pkg::OSS_LOAD;
          idx_nxt = 8'h00;
          pass_nxt = 10'h000;
        end
      end
      oss_pkg::OSS_LOAD: begin
        if (c_stop) begin
          state_nxt = oss_pkg::OSS_IDLE;
        end else begin
          state_nxt = oss_pkg::OSS_RUN;
        end
      end
      oss_pkg::OSS_RUN: begin
        if (c_stop) begin
          state_nxt = oss_pkg::OSS_IDLE;
        end else if (c_branch) begin
          state_nxt = oss_pkg::OSS_LOAD;
          idx_nxt = br_tgt;
        end else if (c_hold) begin
          state_nxt = oss_pkg::OSS_HOLD;
        end else if (expire) begin
          if (!last_step) begin
            state_nxt = oss_pkg::OSS_LOAD;
            idx_nxt = idx_r + 8'h01;
          end else if (more_pass) begin
            state_nxt = oss_pkg::OSS_LOAD;
            idx_nxt = 8'h00;
            pass_nxt = cont ? pass_r : pass_r + 10'h001;
          end else begin
            state_nxt = oss_pkg::OSS_IDLE;
          end
        end
      end
      oss_pkg::OSS_HOLD: begin
        if (c_stop) begin
          state_nxt = oss_pkg::OSS_IDLE;
        end else if (c_branch) begin
          state_nxt = oss_pkg::OSS_LOAD;
          idx_nxt = br_tgt;
        end else if (c_start && src_ok) begin
          state_nxt = oss_pkg::OSS_RUN;
        end
      end
      default: begin
        state_nxt = oss_pkg::OSS_IDLE;
      end
    endcase
  end

  // Software registers; reset here stands for battery loss
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r <= `OSS_CFG_RST;
      seq_r <= `OSS_SEQ_RST;
      stg_a_r <= '0;
      stg_b_r <= '0;
      stg_c_r <= '0;
      stg_d_r <= '0;
    end else begin
      if (wr_cfg) cfg_r <= reg_wdata[7:0];
      if (wr_seq) seq_r <= reg_wdata[25:0];
      if (wr_a) stg_a_r <= reg_wdata;
      if (wr_b) stg_b_r <= reg_wdata[26:0];
      if (wr_c) stg_c_r <= reg_wdata[23:0];
      if (wr_d) stg_d_r <= reg_wdata;
    end
  end

  // Waveform write pointer steps on each accepted sample
  wire fifo_in_ready;
  wire push = wr_wdata && reg_from_usb && fifo_in_ready;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wave_addr_r <= '0;
    end else if (wr_waddr) begin
      wave_addr_r <= reg_wdata[13:0];
    end else if (push) begin
      wave_addr_r <= wave_addr_r + 14'h0001;
    end
  end

  // Dividers: tick restarts with each step and freezes in hold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      samp_cnt_r <= '0;
    end else begin
      if (state_r != oss_pkg::OSS_RUN && state_r != oss_pkg::OSS_HOLD)
        tick_cnt_r <= '0;
      else if (tick)
        tick_cnt_r <= '0;
      else if (state_r == oss_pkg::OSS_RUN)
        tick_cnt_r <= tick_cnt_r + 1'b1;
      samp_cnt_r <= samp_en ? '0 : samp_cnt_r + 1'b1;
    end
  end

  // Inputs idle high; sampled on the 2 ms enable only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_q_r <= 4'hF;
      ext_prev_r <= 4'hF;
    end else if (samp_en) begin
      ext_q_r <= {ext_branch_n, ext_hold_n, ext_stop_n, ext_start_n};
      ext_prev_r <= ext_q_r;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= oss_pkg::OSS_IDLE;
      idx_r <= '0;
      pass_r <= '0;
      kind_r <= oss_pkg::OSS_SINE;
      refused_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      pass_r <= pass_nxt;
      if (state_r == oss_pkg::OSS_IDLE && go_load)
        kind_r <= oss_pkg::oss_kind_t'(kind_cfg);
      if (c_start && !src_ok)
        refused_r <= 1'b1;
      else if (c_start && go_load)
        refused_r <= 1'b0;
    end
  end

  // Output parameters: load on step entry, sweep per tick, hold freezes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_r <= '0;
      timer_r <= '0;
      dc_r <= '0;
      ac_r <= '0;
      freq_r <= '0;
      wave_sel_r <= '0;
      sync_r <= '0;
    end else if (state_r == oss_pkg::OSS_LOAD) begin
      cur_r <= rec;
      timer_r <= (rec.dur == 24'h00_0000) ? 24'h00_0001 : rec.dur;
      dc_r <= rec.dc;
      ac_r <= rec.ac;
      freq_r <= rec.freq;
      sync_r <= rec.sync;
      wave_sel_r <= (kind_r == oss_pkg::OSS_ARB) ? rec.wave : 4'h0;
    end else if (tick) begin
      timer_r <= timer_r - 24'h00_0001;
      if (cur_r.sweep) begin
        dc_r <= dc_r + cur_r.dc_inc;
        ac_r <= ac_r + cur_r.ac_inc;
      end
    end
  end

  // Step table: mode bit picks the voltage or current sequence
  wire [RW-1:0] stg_rec = {stg_c_r, stg_d_r, stg_a_r, stg_b_r};
  oss_mem #(
    .DW(RW),
    .AW(9)
  ) u_step_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_step),
    .wr_addr(reg_wdata[8:0]),
    .wr_data(stg_rec),
    .rd_en(go_load),
    .rd_addr({mode_cc, idx_nxt}),
    .rd_data(rec_bits)
  );

  // Waveform samples queue up before the memory write port
  wire fifo_out_valid;
  wire [29:0] fifo_out_data;
  oss_fifo #(
    .W(30),
    .DEPTH(FIFO_DEPTH)
  ) u_wave_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(wr_wdata && reg_from_usb),
    .in_ready(fifo_in_ready),
    .in_data({wave_addr_r, reg_wdata[15:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(wave_wen),
    .out_data(fifo_out_data)
  );

  // Sixteen waveforms of 1024 words; no reset keeps the contents
  oss_mem #(
    .DW(16),
    .AW(14)
  ) u_wave_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(fifo_out_valid && wave_wen),
    .wr_addr(fifo_out_data[29:16]),
    .wr_data(fifo_out_data[15:0]),
    .rd_en(1'b1),
    .rd_addr({wave_sel_r, gen_phase}),
    .rd_data(gen_sample)
  );

  // Read mux; unmapped addresses read zero
  wire [31:0] status = {9'h000, !fifo_out_valid, fifo_in_ready,
                        refused_r, pass_r, idx_r, state_r};
  wire [31:0] rd_mux =
    (reg_addr == `OSS_REG_CFG) ? {24'h00_0000, cfg_r} :
    (reg_addr == `OSS_REG_SEQ) ? {6'h00, seq_r} :
    (reg_addr == `OSS_REG_STATUS) ? status :
    (reg_addr == `OSS_REG_STEP_A) ? stg_a_r :
    (reg_addr == `OSS_REG_STEP_B) ? {5'h00, stg_b_r} :
    (reg_addr == `OSS_REG_STEP_C) ? {8'h00, stg_c_r} :
    (reg_addr == `OSS_REG_STEP_D) ? stg_d_r :
    (reg_addr == `OSS_REG_WAVE_ADDR) ? {18'h0_0000, wave_addr_r} :
    32'h0000_0000;

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= '0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign dc_level = dc_r;
  assign ac_amp = ac_r;
  assign freq = freq_r;
  assign wave_kind = kind_r;
  assign wave_sel = wave_sel_r;
  assign step_sync = sync_r;
  assign seq_running = (state_r != oss_pkg::OSS_IDLE);
  assign wave_fifo_ready = fifo_in_ready;
endmodule // oss_sequencer

// [tb/oss_host_model.sv]
`timescale 1ns/1ps
module oss_host_model (
  input wire logic clk_sys, // System clock
  output logic [7:0] reg_addr, // Register address
  output logic [31:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic reg_from_usb, // Access travels over USB
  input wire logic [31:0] reg_rdata // Read data
);
  // Quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_from_usb = 1'b1;
  end
  // Released lines carry the inverse, so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic usb);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_from_usb <= usb;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // oss_host_model

// [tb/oss_sequencer_properties.sv]
`timescale 1ns/1ps
`include "oss_defs.svh"
module oss_sequencer_properties (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_from_usb, // Access from USB host
  input wire logic [15:0] dc_level, // DC level
  input wire logic [15:0] ac_amp, // AC amplitude
  input wire logic [1:0] wave_kind, // Waveform kind
  input wire logic [3:0] wave_sel, // Arbitrary memory in use
  input wire logic [1:0] step_sync, // Step sync output
  input wire logic seq_running, // Sequence active or held
  input wire logic wave_fifo_ready // Waveform FIFO room
);
  logic [1:0] src_r;
  // Command decode; exact codes keep combined commands out of the start, hold and branch checks
  wire cmd_wr = reg_wr && (reg_addr == `OSS_REG_CMD);
  wire start_c = cmd_wr && (reg_wdata[3:0] == 4'h1);
  wire hold_c = cmd_wr && (reg_wdata[3:0] == 4'h4);
  wire branch_c = cmd_wr && (reg_wdata[3:0] == 4'h8);
  wire stop_c = cmd_wr && reg_wdata[1];
  wire panel_c = reg_wr && (reg_addr == `OSS_REG_WAVE_DATA) && !reg_from_usb;
  // Shadow of the source field, so refused starts can be predicted here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_r <= 2'h0;
    end else if (reg_wr && (reg_addr == `OSS_REG_CFG)) begin
      src_r <= reg_wdata[6:5];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  start_load_a: assert property (
    start_c && !seq_running && !src_r[0] |=> seq_running [*2])
    else $error("accepted start did not run");
  start_refuse_a: assert property (
    start_c && !seq_running && src_r[0] |=> !seq_running [*3])
    else $error("start on external source ran");
  stop_end_a: assert property (
    stop_c |=> !seq_running)
    else $error("stop did not end the sequence");
  branch_idle_a: assert property (
    branch_c && !seq_running |=> !seq_running)
    else $error("branch while idle started a run");
  hold_freeze_a: assert property (
    hold_c && seq_running |=> ##1
    ($stable(dc_level) && $stable(ac_amp) && $stable(step_sync)) [*6])
    else $error("outputs moved during hold");
  kind_fixed_a: assert property (
    seq_running && $past(seq_running) |-> $stable(wave_kind))
    else $error("waveform kind changed during a run");
  fixed_sel_a: assert property (
    seq_running && $past(seq_running) && (wave_kind != 2'h2)
    |-> (wave_sel == 4'h0))
    else $error("memory select moved with a fixed waveform");
  sync_active_a: assert property (
    $changed(step_sync) || $changed(dc_level) |-> $past(seq_running))
    else $error("step outputs changed while idle");
  panel_wave_a: assert property (
    panel_c && wave_fifo_ready |=> wave_fifo_ready)
    else $error("panel write entered the waveform FIFO");
  // Main scenarios
  cover property (hold_c && seq_running);
  cover property (branch_c && seq_running);
  cover property (start_c && src_r[0]);
endmodule // oss_sequencer_properties

bind oss_sequencer oss_sequencer_properties u_oss_sequencer_properties (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_from_usb(reg_from_usb),
  .dc_level(dc_level), .ac_amp(ac_amp), .wave_kind(wave_kind),
  .wave_sel(wave_sel), .step_sync(step_sync), .seq_running(seq_running),
  .wave_fifo_ready(wave_fifo_ready));

// [tb/oss_sequencer_tb_top.sv]
`timescale 1ns/1ps
`include "oss_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t line %0d: got %0h expected %0h", \
  $time, `__LINE__, g, e); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < (n)) begin \
  @(posedge clk_sys); #1; k++; end `CHK(c, 1'b1) end
module oss_sequencer_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic reg_from_usb;
  logic ext_start_n = 1'b1, ext_stop_n = 1'b1;
  logic [9:0] gen_phase = 10'h000;
  logic [15:0] gen_sample, dc_level, ac_amp, dsv;
  logic [19:0] freq;
  logic [1:0] wave_kind, step_sync;
  logic [3:0] wave_sel;
  logic seq_running, wave_fifo_ready;
  logic [31:0] rv;
  logic [9:0] ph [3] = '{10'h003, 10'h00F, 10'h010};
  logic [15:0] ex [3] = '{16'h1003, 16'h100F, 16'h7777};
  oss_pkg::oss_step_t st;
  int errors = 0;
  int n_compared = 0;
  int k = 0;
  int cyc = 0;

  // Short periods keep the run brief
  oss_sequencer #(.TICK_CYC(4), .SAMPLE_CYC(8)) u_oss_sequencer (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_from_usb(reg_from_usb), .reg_rdata(reg_rdata),
    .ext_start_n(ext_start_n), .ext_stop_n(ext_stop_n), .ext_hold_n(1'b1),
    .ext_branch_n(1'b1), .gen_phase(gen_phase), .gen_sample(gen_sample),
    .dc_level(dc_level), .ac_amp(ac_amp), .freq(freq),
    .wave_kind(wave_kind), .wave_sel(wave_sel), .step_sync(step_sync),
    .seq_running(seq_running), .wave_fifo_ready(wave_fifo_ready));
  oss_host_model u_oss_host_model (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_from_usb(reg_from_usb),
    .reg_rdata(reg_rdata));

  // Clock, 100 MHz
  always #5 clk_sys = ~clk_sys;

  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_oss_host_model.wr(a, d, 1'b1);
  endtask
  task automatic r(input logic [7:0] a);
    u_oss_host_model.rd(a, rv);
  endtask
  task automatic cmd(input logic [3:0] c);
    w(`OSS_REG_CMD, {28'h000_0000, c});
  endtask
  // Step record goes in four parts before the commit write
  task automatic put_step(input logic m, input logic [7:0] i,
                          input oss_pkg::oss_step_t s);
    w(`OSS_REG_STEP_C, {8'h00, s.dur});
    w(`OSS_REG_STEP_D, {s.dc_inc, s.ac_inc});
    w(`OSS_REG_STEP_A, {s.dc, s.ac});
    w(`OSS_REG_STEP_B, {5'h00, s.freq, s.wave, s.sync, s.sweep});
    w(`OSS_REG_STEP_WR, {23'h00_0000, m, i});
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      $display("Error at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, a write-only place and an unmapped place
    r(`OSS_REG_CFG); `CHK(rv, 32'h0000_0000)
    r(`OSS_REG_SEQ); `CHK(rv, 32'h0000_0401)
    r(`OSS_REG_STATUS); `CHK(rv, 32'h0060_0000)
    r(`OSS_REG_CMD); `CHK(rv, 32'h0000_0000)
    r(8'h3C); `CHK(rv, 32'h0000_0000)
    // Two steps for voltage mode, one for current mode
    st = '{24'h00_0002, 16'h0000, 16'h0000, 16'h0100, 16'h0020,
           20'h1_2345, 4'h3, 2'h1, 1'b0};
    put_step(1'b0, 8'h00, st);
    st = '{24'h00_0003, 16'h0001, 16'h0002, 16'h0200, 16'h0040,
           20'h0_0100, 4'h5, 2'h2, 1'b1};
    put_step(1'b0, 8'h01, st);
    st = '{24'h00_0002, 16'h0000, 16'h0000, 16'h0300, 16'h0010,
           20'h0_0200, 4'h7, 2'h3, 1'b0};
    put_step(1'b1, 8'h00, st);
    w(`OSS_REG_SEQ, 32'h0004_0202);
    r(`OSS_REG_SEQ); `CHK(rv, 32'h0004_0202)
    // Arbitrary run over two passes, with a hold in mid-sweep
    w(`OSS_REG_CFG, 32'h0000_0004);
    cmd(4'h1);
    `WAITC(step_sync == 2'h1, 4)
    `CHK(dc_level, 16'h0100)
    `CHK(ac_amp, 16'h0020)
    `CHK(freq, 20'h1_2345)
    `CHK(wave_kind, 2'h2)
    `CHK(wave_sel, 4'h3)
    `WAITC(step_sync == 2'h2, 12)
    `CHK(dc_level, 16'h0200)
    `CHK(wave_sel, 4'h5)
    `WAITC(dc_level == 16'h0201, 6)
    `CHK(ac_amp, 16'h0042)
    cmd(4'h4);
    repeat (2) @(posedge clk_sys);
    #1 dsv = dc_level;
    repeat (12) @(posedge clk_sys);
    #1 `CHK(dc_level, dsv)
    r(`OSS_REG_STATUS); `CHK(rv[9:0], {8'h01, 2'h2})
    cmd(4'h1);
    r(`OSS_REG_STATUS); `CHK(rv[9:0], {8'h01, 2'h3})
    `WAITC(step_sync == 2'h1, 20)
    r(`OSS_REG_STATUS); `CHK(rv[19:10], 10'h001)
    `WAITC(!seq_running, 40)
    // External start, branch at once, then external stop
    w(`OSS_REG_CFG, 32'h0000_0014);
    @(posedge clk_sys) ext_start_n <= 1'b0;
    `WAITC(step_sync == 2'h1, 24)
    cmd(4'h8);
    `WAITC(step_sync == 2'h2, 3)
    @(posedge clk_sys) ext_stop_n <= 1'b0;
    `WAITC(!seq_running, 20)
    @(posedge clk_sys) {ext_start_n, ext_stop_n} <= 2'b11;
    // Continuous repeat ends only on stop
    w(`OSS_REG_CFG, 32'h0000_000C);
    cmd(4'h1);
    repeat (80) @(posedge clk_sys);
    #1 `CHK(seq_running, 1'b1)
    cmd(4'h2);
    #1 `CHK(seq_running, 1'b0)
    // Sources: external alone and code 3 refuse, mixed source runs
    for (int s = 1; s < 4; s++) begin
      w(`OSS_REG_CFG, {25'h000_0000, s[1:0], 5'h04});
      cmd(4'h1);
      repeat (3) @(posedge clk_sys);
      #1 `CHK(seq_running, (s == 2))
      r(`OSS_REG_STATUS); `CHK(rv[20], (s != 2))
      cmd(4'h2);
    end
    // Sine and square keep memory select at zero across steps
    for (int kd = 0; kd < 2; kd++) begin
      w(`OSS_REG_CFG, {29'h0000_0000, kd[1:0], 1'b0});
      cmd(4'h1);
      `WAITC(step_sync == 2'h1, 4)
      `WAITC(step_sync == 2'h2, 20)
      `CHK(wave_kind, kd[1:0])
      `CHK(wave_sel, 4'h0)
      cmd(4'h2);
    end
    // Current mode runs its own sequence
    w(`OSS_REG_SEQ, 32'h0000_0101);
    w(`OSS_REG_CFG, 32'h0000_0001);
    cmd(4'h1);
    `WAITC(step_sync == 2'h3, 4)
    `CHK(dc_level, 16'h0300)
    `WAITC(!seq_running, 20)
    // Fill FIFO until it refuses, drain, read memory 0 back
    w(`OSS_REG_CFG, 32'h0000_0000);
    w(`OSS_REG_WAVE_ADDR, 32'h0000_0000);
    for (int i = 0; i < 16; i++) w(`OSS_REG_WAVE_DATA, 32'h0000_1000 + i);
    #1 `CHK(wave_fifo_ready, 1'b0)
    w(`OSS_REG_WAVE_DATA, 32'h0000_DEAD);
    w(`OSS_REG_CFG, 32'h0000_0080);
    repeat (20) @(posedge clk_sys);
    r(`OSS_REG_STATUS); `CHK(rv[22:21], 2'h3)
    u_oss_host_model.wr(`OSS_REG_WAVE_DATA, 32'h0000_BAD0, 1'b0);
    w(`OSS_REG_WAVE_DATA, 32'h0000_7777);
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) gen_phase <= ph[i];
      repeat (2) @(posedge clk_sys);
      #1 `CHK(gen_sample, ex[i])
    end
    print_verdict();
  end
endmodule // oss_sequencer_tb_top
